/* design/kmsc_pkg.sv */
// Constants, offsets and codes for the key matrix scanner
// Contract
// RL1: Debounce and autosleep run from 64kHz tick divided from 128kHz oscillator.
// RL2: Repeat delay, repeat rate and timed interrupt count debounce cycles.
// RL3: Matrix lines are only sensed, never toggled by scanning.
// RL4: Presses and releases are debounced and queued, plus repeat entries.
// RL5: Any number of simultaneous keys is accepted if no ghosts.
// RL6: Entry bits 5:0 hold key number, column times eight plus row.
// RL7: Bit 7 of a read shows more entries, except keys 62 and 63; code shows it for those keys too, but not for repeat codes.
// RL8: Bit 6 of a read tells press from release, except keys 62, 63; code sets it on release for those keys too.
// RL9: Host reads once more after key 62 or 63 to learn more.
// RL10: Queue read clears interrupt when configuration bit 5 picks that mode.
// RL11: Configuration holds timeout, release, autowake enables and clear mode.
// RL12: Configuration bit 7 sets sleep or run; autosleep and autowake update it.
// RL13: Debounce low nibble sets press time, high nibble release time.
// RL14: Debounce field n gives (n+1) times 2ms, 2ms to 32ms.
// RL15: Interrupt register all zero means interrupt never asserts.
// RL16: Interrupt bits 4:0 assert after 1 to 31 debounce cycles after event.
// RL17: Interrupt bits 7:5 assert at queue level from 2 to 14.
// RL18: With both enabled, the first met condition asserts the interrupt.
// RL19: Held key with repeat on queues code 0x7E after programmed delay.
// RL20: Lines outside the matrix size are left free for other use.
// RL21: After overflow the first read returns 0x7F; stored order is kept.
// RL22: Repeat bit 7 enables repeat; one code however many keys held.
// RL23: Press in sleep wakes device; stored after 2ms plus debounce.
// RL24: Empty queue reads 0x3F; device starts asleep after reset.
// RL25: Each queue read returns and removes the oldest entry.
package kmsc_pkg;
   localparam logic [7:0] A_FIFO = 8'h00;
   localparam logic [7:0] A_CFG  = 8'h01;
   localparam logic [7:0] A_DEB  = 8'h02;
   localparam logic [7:0] A_IRQ  = 8'h03;
   localparam logic [7:0] A_REP  = 8'h05;
   localparam logic [7:0] A_SLP  = 8'h06;
   localparam logic [6:0] R_CFG  = 7'h0b;
   localparam logic [7:0] R_DEB  = 8'hff;
   localparam logic [7:0] R_IRQ  = 8'h00;
   localparam logic [7:0] R_REP  = 8'h00;
   localparam logic [7:0] R_SLP  = 8'h07;
   localparam logic [7:0] C_EMPTY  = 8'h3f;
   localparam logic [7:0] C_REPEAT = 8'h7e;
   localparam logic [7:0] C_OVF    = 8'h7f;
   localparam logic [7:0] C_NONE   = 8'h00;
   localparam int CFG_RUN   = 7;
   localparam int CFG_IMODE = 5;
   localparam int CFG_REL   = 3;
   localparam int CFG_WAKE  = 1;
   localparam int REP_EN    = 7;
   localparam int OSC_HZ    = 128_000;
   localparam int TICK_HZ   = 64_000;
   localparam int STEP_US   = 2_000;
   localparam int WAKE_US   = 2_000;
   localparam int STEP_TICKS = TICK_HZ * STEP_US / 1_000_000;
   localparam int WAKE_TICKS = TICK_HZ * WAKE_US / 1_000_000;
   localparam int REP_DLY_UNIT  = 8;
   localparam int REP_RATE_UNIT = 4;
   localparam int LVL_UNIT      = 2;
   localparam int SLP_TICKS     = 16_384;
   localparam int FIFO_DEPTH    = 16;
   typedef enum logic [1:0] {ST_SLEEP, ST_WAKE, ST_RUN} kmsc_st_t;
endpackage

/* design/kmsc_top.sv */
// Key matrix scanner with event queue, interrupt and register port
`timescale 1ns/100ps
module kmsc_top import kmsc_pkg::*; #(
   parameter int         CLK_HZ   = 100_000_000,
   parameter int         DEPTH    = FIFO_DEPTH,
   parameter int         SLP_UNIT = SLP_TICKS,
   parameter logic [7:0] ROW_USE  = 8'hff,
   parameter logic [7:0] COL_USE  = 8'hff
) (
   // Core clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // Register port, link clock domain
   input  wire logic       lclk,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   output logic            reg_ack,
   // Key matrix sense lines, low when closed
   input  wire logic [7:0] row_n,
   input  wire logic [7:0] col_n,
   // Interrupt pin, open drain
   output logic            int_o,
   output logic            int_oe
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int OSC_DIV = CLK_HZ / OSC_HZ;

   function automatic logic [11:0] dticks(input logic [3:0] f);
      return 12'((int'(f) + 1) * STEP_TICKS); // [RL14]
   endfunction

   function automatic logic [63:0] key_map(input logic [7:0] r,
                                           input logic [7:0] c);
      logic [63:0] k;
      k = '0;
      for (int i = 0; i < 64; i++) begin
         k[i] = ~c[i/8] & ~r[i%8] & COL_USE[i/8] & ROW_USE[i%8];
      end
      return k;
   endfunction

   function automatic logic [5:0] first_set(input logic [63:0] v);
      logic [5:0] n;
      n = '0;
      for (int i = 63; i >= 0; i--) begin
         if (v[i]) begin
            n = 6'(i);
         end
      end
      return n;
   endfunction

   // Link side request and answer
   logic       lreq_q;
   logic       lbusy_q;
   logic       lwr_q;
   logic [7:0] laddr_q;
   logic [7:0] lwdat_q;
   logic       la1_q;
   logic       la2_q;
   logic       la3_q;
   logic       cack_q;
   logic [7:0] crd_q;
   wire        lstart = (reg_wr | reg_rd) & ~lbusy_q;
   wire        lack_ev = la2_q ^ la3_q;

   always_ff @(posedge lclk or negedge nrst) begin
      if (!nrst) begin
         lreq_q  <= 1'b0;
         lbusy_q <= 1'b0;
         lwr_q   <= 1'b0;
         laddr_q <= 8'h00;
         lwdat_q <= 8'h00;
      end else if (lstart) begin
         lreq_q  <= ~lreq_q;
         lbusy_q <= 1'b1;
         lwr_q   <= reg_wr;
         laddr_q <= reg_addr;
         lwdat_q <= reg_wdata;
      end else if (reg_ack) begin
         lbusy_q <= 1'b0;
      end
   end

   always_ff @(posedge lclk or negedge nrst) begin
      if (!nrst) begin
         la1_q     <= 1'b0;
         la2_q     <= 1'b0;
         la3_q     <= 1'b0;
         reg_ack   <= 1'b0;
         reg_rdata <= 8'h00;
      end else begin
         la1_q   <= cack_q;
         la2_q   <= la1_q;
         la3_q   <= la2_q;
         reg_ack <= lack_ev;
         if (lack_ev) begin
            reg_rdata <= crd_q;
         end
      end
   end

   // Core side of the crossing
   logic c1_q;
   logic c2_q;
   logic c3_q;
   wire  cev = c2_q ^ c3_q;
   wire  wr_ev = cev & lwr_q;
   wire  rd_fifo = cev & ~lwr_q & (laddr_q == A_FIFO);
   wire  wr_cfg = wr_ev & (laddr_q == A_CFG);

   // Registers
   logic [6:0] cfg_q;
   logic [7:0] deb_q;
   logic [7:0] irq_q;
   logic [7:0] rep_q;
   logic [7:0] slp_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_q <= R_CFG;
         deb_q <= R_DEB;
         irq_q <= R_IRQ;
         rep_q <= R_REP;
         slp_q <= R_SLP;
      end else if (wr_ev) begin
         if (laddr_q == A_CFG) cfg_q <= lwdat_q[6:0]; // [RL11]
         if (laddr_q == A_DEB) deb_q <= lwdat_q; // [RL13]
         if (laddr_q == A_IRQ) irq_q <= lwdat_q;
         if (laddr_q == A_REP) rep_q <= lwdat_q;
         if (laddr_q == A_SLP) slp_q <= lwdat_q;
      end
   end

   // Tick generation
   logic [15:0] osc_q;
   logic        half_q;
   logic        tick_q;
   wire         osc_hit = osc_q == 16'(OSC_DIV - 1);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         osc_q  <= 16'h0000;
         half_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         osc_q  <= osc_hit ? 16'h0000 : osc_q + 16'h0001;
         half_q <= half_q ^ osc_hit;
         tick_q <= osc_hit & half_q; // [RL1]
      end
   end

   // Matrix sampling, sense only
   logic [15:0] ms1_q;
   logic [15:0] ms2_q;
   logic [63:0] rawp_q;
   wire  [63:0] raw = key_map(ms2_q[7:0], ms2_q[15:8]); // [RL3] [RL20]

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         c1_q   <= 1'b0;
         c2_q   <= 1'b0;
         c3_q   <= 1'b0;
         ms1_q  <= 16'hffff;
         ms2_q  <= 16'hffff;
         rawp_q <= 64'h0;
      end else begin
         c1_q   <= lreq_q;
         c2_q   <= c1_q;
         c3_q   <= c2_q;
         ms1_q  <= {col_n, row_n};
         ms2_q  <= ms1_q;
         rawp_q <= raw;
      end
   end

   // Sleep, wake and run
   kmsc_st_t    st_q;
   kmsc_st_t    st_d;
   logic [7:0]  wk_q;
   logic [23:0] idle_q;
   logic [63:0] keys_q;
   wire         run = st_q == ST_RUN;
   wire         wk_done = wk_q >= 8'(WAKE_TICKS);
   wire  [23:0] idle_lim = 24'(slp_q) * 24'(SLP_UNIT);
   wire         idle_hit = (slp_q != 8'h00) & (idle_q >= idle_lim);
   wire         wr_run1 = wr_cfg & lwdat_q[CFG_RUN];
   wire         wr_run0 = wr_cfg & ~lwdat_q[CFG_RUN];

   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_SLEEP: begin
            if (wr_run1) st_d = ST_RUN; // [RL12]
            else if (cfg_q[CFG_WAKE] && |raw) st_d = ST_WAKE; // [RL23]
         end
         ST_WAKE: begin
            if (wr_run0) st_d = ST_SLEEP;
            else if (wk_done || wr_run1) st_d = ST_RUN; // [RL23]
         end
         ST_RUN: begin
            if (wr_run0 || idle_hit) st_d = ST_SLEEP; // [RL12]
         end
         default: st_d = ST_SLEEP;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q   <= ST_SLEEP; // [RL24]
         wk_q   <= 8'h00;
         idle_q <= 24'h0;
      end else begin
         st_q <= st_d;
         if (st_q != ST_WAKE) wk_q <= 8'h00;
         else if (tick_q) wk_q <= wk_q + 8'h01;
         if (!run || |raw || |keys_q) idle_q <= 24'h0;
         else if (tick_q && !idle_hit) idle_q <= idle_q + 24'h1; // [RL1]
      end
   end

   // Debounce of presses and releases
   logic [11:0] dcnt_q;
   wire  [63:0] diff = raw ^ keys_q;
   wire         newp = |(diff & raw);
   wire  [11:0] dlim = newp ? dticks(deb_q[3:0]) : dticks(deb_q[7:4]);
   wire         stable = (raw == rawp_q) & (dcnt_q >= dlim);
   wire         kev = run & stable & |diff; // [RL5]
   wire  [5:0]  kidx = first_set(diff);
   wire         kpress = raw[kidx];
   wire         kev_push = kev & (kpress | cfg_q[CFG_REL]); // [RL11]

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dcnt_q <= 12'h000;
         keys_q <= 64'h0;
      end else begin
         if (!run || raw != rawp_q) dcnt_q <= 12'h000;
         else if (tick_q && !stable) dcnt_q <= dcnt_q + 12'h001; // [RL13]
         if (kev) keys_q[kidx] <= kpress; // [RL4]
      end
   end

   // Debounce cycle beat for repeat and timed interrupt
   logic [11:0] dcy_q;
   logic        dcyc_q;
   wire         dcy_hit = tick_q & (dcy_q >= dticks(deb_q[3:0]) - 12'h001);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dcy_q  <= 12'h000;
         dcyc_q <= 1'b0;
      end else begin
         if (dcy_hit || kev) dcy_q <= 12'h000; // [RL2]
         else if (tick_q) dcy_q <= dcy_q + 12'h001;
         dcyc_q <= dcy_hit; // [RL2]
      end
   end

   // Autorepeat
   logic [7:0] rcnt_q;
   wire  [7:0] rdly = 8'((int'(rep_q[3:0]) + 1) * REP_DLY_UNIT);
   wire  [7:0] rrate = 8'((int'(rep_q[6:4]) + 1) * REP_RATE_UNIT);
   wire        held = |keys_q;
   wire        rep_push = run & dcyc_q & rep_q[REP_EN] & held &
                          (rcnt_q <= 8'h01) & ~kev; // [RL19] [RL22]

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rcnt_q <= 8'h00;
      end else if (kev || !held) begin
         rcnt_q <= rdly; // [RL2]
      end else if (rep_push) begin
         rcnt_q <= rrate; // [RL19]
      end else if (dcyc_q && rcnt_q > 8'h01) begin
         rcnt_q <= rcnt_q - 8'h01;
      end
   end

   // Event queue
   logic [7:0]    mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [CW-1:0] cnt_q;
   logic          ovf_q;
   wire           full = cnt_q == CW'(DEPTH);
   wire           empty = cnt_q == '0;
   wire           push_req = kev_push | rep_push;
   wire           push = push_req & ~full;
   wire           pop = rd_fifo & ~ovf_q & ~empty; // [RL25]
   wire  [CW-1:0] cnt_d = cnt_q + CW'(push & ~pop) - CW'(pop & ~push);
   wire  [7:0]    ent = kev_push ? {1'b0, ~kpress, kidx} // [RL6] [RL8]
                                 : {1'b1, C_REPEAT[6:0]};
   wire  [7:0]    head = mem_q[rp_q];
   wire           more = cnt_q > CW'(1);
   wire  [7:0]    fifo_val = ovf_q ? C_OVF // [RL21]
                           : empty ? C_EMPTY // [RL24]
                           : head[7] ? {1'b0, head[6:0]}
                           : {more, head[6:0]}; // [RL7] [RL9]

   always_ff @(posedge clk) begin
      if (push) mem_q[wp_q] <= ent; // [RL4]
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
         ovf_q <= 1'b0;
      end else begin
         if (push) wp_q <= wp_q + AW'(1);
         if (pop) rp_q <= rp_q + AW'(1); // [RL25]
         if (push && !pop) cnt_q <= cnt_q + CW'(1);
         else if (pop && !push) cnt_q <= cnt_q - CW'(1);
         if (push_req && full) ovf_q <= 1'b1; // [RL21]
         else if (rd_fifo) ovf_q <= 1'b0;
      end
   end

   // Interrupt
   logic [4:0] tcnt_q;
   logic       tact_q;
   logic       int_q;
   wire  [4:0] tsel = irq_q[4:0];
   wire  [2:0] lsel = irq_q[7:5];
   wire        lvl_hit = (lsel != 3'h0) &
                         (cnt_d >= CW'(int'(lsel) * LVL_UNIT)); // [RL17]
   wire        thit = tact_q & dcyc_q & (tcnt_q <= 5'h01) &
                      (tsel != 5'h00); // [RL16] [RL15]
   wire        int_set = lvl_hit | thit; // [RL18]
   wire        int_clr = cfg_q[CFG_IMODE] ? (empty & ~ovf_q)
                                          : rd_fifo; // [RL10]

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tcnt_q <= 5'd0;
         tact_q <= 1'b0;
      end else if (push) begin
         tcnt_q <= tsel;
         tact_q <= tsel != 5'd0; // [RL16]
      end else if (thit) begin
         tact_q <= 1'b0;
      end else if (tact_q && dcyc_q) begin
         tcnt_q <= tcnt_q - 5'd1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         int_q  <= 1'b0;
         int_oe <= 1'b0;
         int_o  <= 1'b0;
      end else begin
         int_q  <= int_set | (int_q & ~int_clr); // [RL15]
         int_oe <= int_set | (int_q & ~int_clr);
         int_o  <= 1'b0;
      end
   end

   // Register read and answer
   wire [7:0] rd_mux = (laddr_q == A_FIFO) ? fifo_val
                     : (laddr_q == A_CFG) ? {run, cfg_q} // [RL12]
                     : (laddr_q == A_DEB) ? deb_q
                     : (laddr_q == A_IRQ) ? irq_q
                     : (laddr_q == A_REP) ? rep_q
                     : (laddr_q == A_SLP) ? slp_q
                     : C_NONE;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         crd_q  <= 8'h00;
         cack_q <= 1'b0;
      end else if (cev) begin
         crd_q  <= lwr_q ? 8'h00 : rd_mux;
         cack_q <= ~cack_q;
      end
   end

   // Checks
   a_empty_read: assert property (@(posedge clk) disable iff (!nrst)
      rd_fifo && empty && !ovf_q |=> crd_q == C_EMPTY) // [RL24]
      else $error("empty read not 0x3f");
   a_ovf_first: assert property (@(posedge clk) disable iff (!nrst)
      rd_fifo && ovf_q |=> crd_q == C_OVF && !ovf_q || $past(push_req))
      else $error("overflow code not returned first"); // [RL21]
   a_int_off: assert property (@(posedge clk) disable iff (!nrst)
      irq_q == R_IRQ && !int_oe |=> !int_oe) // [RL15]
      else $error("interrupt asserted while disabled");
   a_read_clr: assert property (@(posedge clk) disable iff (!nrst)
      rd_fifo && !cfg_q[CFG_IMODE] && !int_set |=> !int_oe) // [RL10]
      else $error("queue read left interrupt active");
   a_pop_count: assert property (@(posedge clk) disable iff (!nrst)
      pop && !push |=> cnt_q == $past(cnt_q) - CW'(1)) // [RL25]
      else $error("read did not remove one entry");
   a_more_bit: assert property (@(posedge clk) disable iff (!nrst)
      rd_fifo && !ovf_q && more && !head[7] |=> crd_q[7]) // [RL7]
      else $error("more bit clear with entries left");
   a_level_int: assert property (@(posedge clk) disable iff (!nrst)
      lvl_hit |=> int_oe) // [RL17]
      else $error("level interrupt missed");
   a_rel_gate: assert property (@(posedge clk) disable iff (!nrst)
      kev && !kpress && !cfg_q[CFG_REL] |-> !push || rep_push) // [RL11]
      else $error("release queued while disabled");
   a_sleep_quiet: assert property (@(posedge clk) disable iff (!nrst)
      st_q == ST_SLEEP |-> !kev && !rep_push) // [RL23]
      else $error("event queued while asleep");
   a_wake_hold: assert property (@(posedge clk) disable iff (!nrst)
      st_q == ST_SLEEP && st_d == ST_WAKE && !wr_ev
      |=> st_q == ST_WAKE [*8]) // [RL23]
      else $error("wake delay cut short");
endmodule // kmsc_top

/* tb/kmsc_keys.sv */
// Key switch matrix model driving the row and column sense lines
`timescale 1ns/100ps
module kmsc_keys (
   // Held key
   input  wire logic       press,
   input  wire logic [5:0] key,
   // Sense lines, pulled up while open
   output logic      [7:0] row_n,
   output logic      [7:0] col_n
);
   // Closed switch grounds its row and its column
   always_comb begin
      row_n = 8'hff;
      col_n = 8'hff;
      if (press) begin
         row_n[key[2:0]] = 1'b0;
         col_n[key[5:3]] = 1'b0;
      end
   end
endmodule // kmsc_keys

/* tb/key_matrix_scan_fifo_irq_tb_top.sv */
// Self-checking bench for the key matrix scanner
`timescale 1ns/100ps
module key_matrix_scan_fifo_irq_tb_top import kmsc_pkg::*;;
   localparam int CLK_F = 256_000;
   localparam int DEB   = (CLK_F / OSC_HZ) * 2 * STEP_TICKS;
   localparam int T     = DEB * 5 / 4;
   localparam int LIMIT = 60_000;
   logic       clk;
   logic       lclk;
   logic       nrst;
   logic       reg_wr;
   logic       reg_rd;
   logic       reg_ack;
   logic       press;
   logic       int_o;
   logic       int_oe;
   logic       int_n;
   logic       seen_int;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [7:0] rd;
   logic [7:0] row_n;
   logic [7:0] col_n;
   logic [5:0] key;
   logic [5:0] k;
   int         miscompares;
   int         checks;
   int         cyc;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      lclk = 1'b0;
      #1.7;
      forever #3 lclk = ~lclk;
   end

   // Open-drain pin level with pull-up
   assign int_n = int_oe ? int_o : 1'b1;

   kmsc_top #(.CLK_HZ(CLK_F), .SLP_UNIT(4)) dut (
      .clk(clk), .nrst(nrst), .lclk(lclk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack), .row_n(row_n),
      .col_n(col_n), .int_o(int_o), .int_oe(int_oe)
   );
   kmsc_keys keys (
      .press(press), .key(key), .row_n(row_n), .col_n(col_n)
   );

   task automatic test_done();
      if (miscompares == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (int_oe === 1'b1) seen_int <= 1'b1;
      if (cyc == LIMIT) begin
         miscompares++;
         $display("[ERR] %0t run too long", $time);
         test_done();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] ev(input logic m, input logic r,
                                     input logic [5:0] kk);
      return {m, r, kk};
   endfunction

   // Register request held until acknowledge is sampled
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
      int n;
      @(posedge lclk);
      #1;
      reg_wr = w;
      reg_rd = ~w;
      reg_addr = a;
      reg_wdata = d;
      n = 0;
      do begin
         @(posedge lclk);
         n++;
      end while (reg_ack !== 1'b1 && n < 40);
      if (n >= 40) begin
         miscompares++;
         $display("[ERR] %0t no acknowledge", $time);
      end
      rd = reg_rdata;
      #1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      xfer(1'b0, a, 8'h00);
      chk(rd, exp);
   endtask

   task automatic ks(input logic on, input logic [5:0] kk, input int n);
      @(posedge clk);
      #1;
      press = on;
      key = kk;
      repeat (n) @(posedge clk);
   endtask

   task automatic tap(input logic [5:0] kk);
      ks(1'b1, kk, T);
      ks(1'b0, kk, T);
   endtask

   initial begin
      nrst = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      press = 1'b0;
      key = 6'h00;
      seen_int = 1'b0;
      miscompares = 0;
      checks = 0;
      cyc = 0;
      void'($urandom(24862));
      repeat (8) @(posedge clk);
      #1 nrst = 1'b1;
      rc(A_FIFO, C_EMPTY);
      rc(A_CFG, {1'b0, R_CFG});
      rc(A_DEB, R_DEB);
      rc(A_IRQ, R_IRQ);
      rc(A_REP, R_REP);
      rc(A_SLP, R_SLP);
      rc(8'h04, C_NONE);
      wr(A_FIFO, 8'h12);
      rc(A_FIFO, C_EMPTY);
      wr(A_DEB, 8'h00);
      wr(A_SLP, 8'h00);
      wr(A_CFG, 8'h8a);
      rc(A_CFG, 8'h8a);
      // Single keys, keys 0 and 61 then random
      for (int i = 0; i < 4; i++) begin
         k = (i == 0) ? 6'd0 : (i == 1) ? 6'd61 : 6'($urandom_range(60, 1));
         tap(k);
         rc(A_FIFO, ev(1'b1, 1'b0, k));
         rc(A_FIFO, ev(1'b0, 1'b1, k));
         rc(A_FIFO, C_EMPTY);
      end
      chk({7'h00, seen_int}, 8'h00);
      tap(6'd63);
      xfer(1'b0, A_FIFO, 8'h00);
      chk({2'b00, rd[5:0]}, 8'h3f);
      xfer(1'b0, A_FIFO, 8'h00);
      chk({2'b00, rd[5:0]}, 8'h3f);
      rc(A_FIFO, C_EMPTY);
      // Release detection off
      wr(A_CFG, 8'h82);
      tap(6'd9);
      rc(A_FIFO, ev(1'b0, 1'b0, 6'd9));
      wr(A_CFG, 8'h8a);
      // Press shorter than a 4ms press debounce
      wr(A_DEB, 8'h01);
      ks(1'b1, 6'd5, DEB * 3 / 2);
      ks(1'b0, 6'd5, T);
      rc(A_FIFO, C_EMPTY);
      wr(A_DEB, 8'h00);
      // Level interrupt at two entries, cleared by read
      wr(A_IRQ, 8'h20);
      ks(1'b1, 6'd20, T);
      chk({7'h00, int_n}, 8'h01);
      ks(1'b0, 6'd20, T);
      chk({7'h00, int_n}, 8'h00);
      rc(A_FIFO, ev(1'b1, 1'b0, 6'd20));
      chk({7'h00, int_n}, 8'h01);
      rc(A_FIFO, ev(1'b0, 1'b1, 6'd20));
      // Interrupt held until the queue drains
      wr(A_CFG, 8'haa);
      tap(6'd50);
      chk({7'h00, int_n}, 8'h00);
      rc(A_FIFO, ev(1'b1, 1'b0, 6'd50));
      chk({7'h00, int_n}, 8'h00);
      rc(A_FIFO, ev(1'b0, 1'b1, 6'd50));
      chk({7'h00, int_n}, 8'h01);
      wr(A_CFG, 8'h8a);
      // Timed interrupt one debounce cycle after the event
      wr(A_IRQ, 8'h21);
      ks(1'b1, 6'd33, DEB * 3 / 2);
      chk({7'h00, int_n}, 8'h01);
      repeat (DEB) @(posedge clk);
      chk({7'h00, int_n}, 8'h00);
      ks(1'b0, 6'd33, T);
      rc(A_FIFO, ev(1'b1, 1'b0, 6'd33));
      rc(A_FIFO, ev(1'b0, 1'b1, 6'd33));
      wr(A_IRQ, 8'h00);
      // Overflow keeps the stored order
      for (int i = 0; i < 9; i++) tap(i[5:0]);
      rc(A_FIFO, C_OVF);
      for (int j = 0; j < 16; j++) begin
         rc(A_FIFO, ev(j < 15, j[0], j[6:1]));
      end
      rc(A_FIFO, C_EMPTY);
      // Held key gives one repeat code after eight cycles
      wr(A_REP, 8'h80);
      ks(1'b1, 6'd44, 11 * DEB);
      ks(1'b0, 6'd44, T);
      rc(A_FIFO, ev(1'b1, 1'b0, 6'd44));
      rc(A_FIFO, C_REPEAT);
      rc(A_FIFO, ev(1'b0, 1'b1, 6'd44));
      wr(A_REP, 8'h00);
      // Sleep, wake by key, then autosleep
      wr(A_CFG, 8'h0a);
      rc(A_CFG, 8'h0a);
      ks(1'b1, 6'd27, 2 * DEB + DEB / 4);
      rc(A_CFG, 8'h8a);
      ks(1'b0, 6'd27, T);
      rc(A_FIFO, ev(1'b1, 1'b0, 6'd27));
      rc(A_FIFO, ev(1'b0, 1'b1, 6'd27));
      wr(A_SLP, 8'h01);
      repeat (100) @(posedge clk);
      rc(A_CFG, 8'h0a);
      test_done();
   end
endmodule // key_matrix_scan_fifo_irq_tb_top
